// ==== verilog/rpl_pkg.sv ====
`default_nettype none
package rpl_pkg;
  // Common range addresses
  localparam logic [7:0] ADDR_OPERATION_CONTROL = 8'hF0;
  localparam logic [7:0] ADDR_IND = 8'hFC;
  localparam logic [7:0] ADDR_REGCTL = 8'hFF;
  localparam logic [7:0] COMMON_BASE = 8'hF0;
  // Register control fields
  localparam int RC_PAGE = 0;
  localparam int RC_BROADCAST_READ_ENABLE = 2;
  localparam int RC_MLK_LO = 4;
  localparam int RC_CONF = 7;
  localparam logic RC_CONF_RST = 1'b1;
  localparam logic [1:0] MLK_OPEN = 2'h0;
  localparam logic [1:0] MLK_REQ = 2'h1;
  localparam logic [1:0] MLK_HELD = 2'h2;
  // Operation control fields
  localparam int OC_SLEEP = 0;
  localparam int OC_CLR = 1;
  localparam int OC_SINGLE_MEASUREMENT = 2;
  localparam int OC_CONTINUOUS_MEASURE = 3;
  localparam int OC_UPD = 5;
  localparam int OC_RST = 7;
  // Memory organisation
  localparam int ROW_BYTES = 16;
  localparam int MEM_WORDS = 512;
  localparam logic [4:0] RESYNC_LAST = 5'h1F;
  localparam logic [7:0] BLOCK_DATA = 8'hFF;
  // Configuration update time
  localparam int UPD_TIME_MS = 100;
  localparam int CLK_HZ = 100_000_000;
  localparam int UPD_CYCLES_DEF = UPD_TIME_MS * (CLK_HZ / 1000);
  typedef enum logic [1:0] {CS_SLEEP, CS_STANDBY, CS_MEASURE} rpl_core_t;
endpackage
`default_nettype wire

// ==== verilog/rpl_operation_control.sv ====
`timescale 1ns/10ps
`default_nettype none
module rpl_operation_control #(
  parameter int UPD_CYCLES = rpl_pkg::UPD_CYCLES_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register write
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] opc_value,
  // Wake and reset unlock
  input wire logic wake,
  input wire logic reset_unlock,
  // Measurement engine
  input wire logic meas_done,
  input wire logic clear_done,
  output logic meas_start_r,
  output logic accum_enable_r,
  output logic clear_accum_r,
  output logic cfg_apply_r,
  output logic soft_reset_r,
  output rpl_pkg::rpl_core_t state_r
);
  localparam int CW = $clog2(UPD_CYCLES + 1);
  logic sleep_r, clr_r, single_measurement_r, continuous_measure_r, upd_r, single_r;
  logic [CW-1:0] upd_cnt_r;

  always_comb begin
    opc_value = '0;
    opc_value[rpl_pkg::OC_SLEEP] = sleep_r;
    opc_value[rpl_pkg::OC_CLR] = clr_r;
    opc_value[rpl_pkg::OC_SINGLE_MEASUREMENT] = single_measurement_r;
    opc_value[rpl_pkg::OC_CONTINUOUS_MEASURE] = continuous_measure_r;
    opc_value[rpl_pkg::OC_UPD] = upd_r;
  end

  // Sleep leaves through a wake event or a host write, never by the engine
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sleep_r <= 1'b0;
    end else if (wr_en) begin
      sleep_r <= wr_data[rpl_pkg::OC_SLEEP];
    end else if (sleep_r && wake) begin
      sleep_r <= 1'b0; // RULE17
    end
  end

  // Measurement sequencing; a fresh single-shot request beats completion
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= rpl_pkg::CS_STANDBY;
      single_measurement_r <= 1'b0;
      continuous_measure_r <= 1'b0;
      single_r <= 1'b0;
      meas_start_r <= 1'b0;
    end else begin
      meas_start_r <= 1'b0;
      if (wr_en) begin
        continuous_measure_r <= wr_data[rpl_pkg::OC_CONTINUOUS_MEASURE]; // RULE21
      end
      unique case (state_r)
        rpl_pkg::CS_SLEEP: begin
          if (!sleep_r) begin
            state_r <= rpl_pkg::CS_STANDBY;
          end
        end
        rpl_pkg::CS_STANDBY: begin // RULE25
          if (sleep_r) begin
            state_r <= rpl_pkg::CS_SLEEP;
          end else if (single_measurement_r) begin
            state_r <= rpl_pkg::CS_MEASURE; // RULE19
            meas_start_r <= 1'b1;
            single_r <= 1'b1;
            continuous_measure_r <= 1'b0; // RULE20
          end else if (continuous_measure_r) begin
            state_r <= rpl_pkg::CS_MEASURE;
            meas_start_r <= 1'b1;
            single_r <= 1'b0;
          end
        end
        rpl_pkg::CS_MEASURE: begin
          if (meas_done) begin
            if (single_r) begin
              single_measurement_r <= 1'b0; // RULE1 RULE19
              single_r <= 1'b0;
              state_r <= rpl_pkg::CS_STANDBY;
            end else if (single_measurement_r) begin
              continuous_measure_r <= 1'b0; // RULE20
              single_r <= 1'b1;
              meas_start_r <= 1'b1;
            end else if (continuous_measure_r) begin
              meas_start_r <= 1'b1; // RULE21
            end else begin
              state_r <= rpl_pkg::CS_STANDBY;
            end
          end
        end
      endcase
      if (wr_en && wr_data[rpl_pkg::OC_SINGLE_MEASUREMENT]) begin
        single_measurement_r <= 1'b1;
      end
    end
  end

  // Accumulation only while repeating cycles run
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      accum_enable_r <= 1'b0;
    end else begin
      accum_enable_r <= (state_r == rpl_pkg::CS_MEASURE) && continuous_measure_r &&
                        !single_r; // RULE21
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clr_r <= 1'b0;
      clear_accum_r <= 1'b0;
    end else begin
      clear_accum_r <= wr_en && wr_data[rpl_pkg::OC_CLR]; // RULE18
      if (wr_en && wr_data[rpl_pkg::OC_CLR]) begin
        clr_r <= 1'b1;
      end else if (clear_done) begin
        clr_r <= 1'b0; // RULE1 RULE18
      end
    end
  end

  // Fixed worst-case wait keeps the update independent of the engine
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      upd_r <= 1'b0;
      upd_cnt_r <= '0;
      cfg_apply_r <= 1'b0;
    end else begin
      cfg_apply_r <= 1'b0;
      if (upd_r) begin
        if (upd_cnt_r == CW'(UPD_CYCLES - 1)) begin
          upd_r <= 1'b0; // RULE22 RULE24
          upd_cnt_r <= '0;
          cfg_apply_r <= 1'b1;
        end else begin
          upd_cnt_r <= upd_cnt_r + 1'b1;
        end
      end
      if (wr_en && wr_data[rpl_pkg::OC_UPD]) begin
        upd_r <= 1'b1;
      end
    end
  end

  // Reset request acts at once, so the bit always reads back zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= wr_en && wr_data[rpl_pkg::OC_RST] &&
                      reset_unlock; // RULE23
    end
  end
endmodule
`default_nettype wire

// ==== verilog/rpl_regbank.sv ====
`timescale 1ns/10ps
`default_nettype none
// Operation
// RULE1 - Set-only bits clear themselves when done
// RULE2 - Host waits for set-only bits zero
// RULE3 - Two pages of bytes, 0x00 to 0xEF
// RULE4 - 0xF0 to 0xFF shared by both pages
// RULE5 - Most significant byte at lowest address
// RULE6 - Memory reads MSB first, fast LSB first
// RULE7 - Reserved bits written zero, unused reads arbitrary
// RULE8 - Control bit 0 selects page
// RULE9 - Control bit 2 enables broadcast reads
// RULE10 - Control bit 7 picks fast or indirect
// RULE11 - Lock field: open, requested, held
// RULE12 - Pending lock blocks all but two registers
// RULE13 - Device grants lock after pending updates
// RULE14 - Held lock freezes map until host opens
// RULE15 - Internal state keeps updating while locked
// RULE16 - Bursts within one row stay coherent
// RULE17 - Sleep bit; wake by select or pulse
// RULE18 - Clear bit wipes accumulators and trackers
// RULE19 - Single shot runs one set, then standby
// RULE20 - Single shot ends continuous mode first
// RULE21 - Continuous mode; accumulation only then
// RULE22 - Update bit applies page-two configuration
// RULE23 - Reset bit works only when unlocked
// RULE24 - Update finishes within 100 ms
// RULE25 - Operation control at 0xF0 steers states
module rpl_regbank #(
  parameter int FAST_BYTES = 3,
  parameter int UPD_CYCLES = rpl_pkg::UPD_CYCLES_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Host register access
  input wire logic host_req,
  input wire logic host_we,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_burst,
  output logic host_ack,
  output logic host_refused,
  output logic [7:0] host_rdata,
  // Read-conversion command
  input wire logic read_conversion_command_req,
  input wire logic read_conversion_command_first,
  input wire logic read_conversion_command_bcast,
  input wire logic [8*FAST_BYTES-1:0] fast_result,
  output logic read_conversion_command_ack,
  output logic [7:0] read_conversion_command_rdata,
  // Internal row updates
  input wire logic core_row_we,
  input wire logic core_page,
  input wire logic [3:0] core_row,
  input wire logic [8*rpl_pkg::ROW_BYTES-1:0] core_row_data,
  input wire logic core_busy,
  output logic core_row_ready,
  // Core control
  input wire logic chip_select_n,
  input wire logic iso_wake,
  input wire logic reset_unlock,
  input wire logic meas_done,
  input wire logic clear_done,
  output logic meas_start,
  output logic accum_enable,
  output logic clear_accum,
  output logic cfg_apply,
  output logic soft_reset,
  output rpl_pkg::rpl_core_t core_state
);
  localparam int RB = rpl_pkg::ROW_BYTES;
  logic [7:0] mem_int [0:rpl_pkg::MEM_WORDS-1];
  logic [7:0] mem_vis [0:rpl_pkg::MEM_WORDS-1];
  logic [7:0] common_r [0:RB-1];
  logic [7:0] ind_addr_r;
  logic page_r, broadcast_read_enable_r, conf_r;
  logic [1:0] mlk_r;
  logic resync_r;
  logic [4:0] resync_row_r;
  logic [7:0] ptr_r;
  logic [7:0] fast_idx_r;
  logic [7:0] opc_value;
  logic host_ok, host_wr, host_main_wr, core_wr, opc_we, unlock_ev;
  logic regctl_wr;
  logic [7:0] read_conversion_command_addr, read_conversion_command_idx;

  function automatic logic is_common(input logic [7:0] a);
    return a >= rpl_pkg::COMMON_BASE; // RULE4
  endfunction

  function automatic logic blocked(input logic [7:0] a);
    logic lock_wait;
    lock_wait = (mlk_r == rpl_pkg::MLK_REQ) &&
                (a != rpl_pkg::ADDR_REGCTL) && (a != rpl_pkg::ADDR_IND);
    return lock_wait || (resync_r && !is_common(a)); // RULE12
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [7:0] v;
    v = mem_vis[{page_r, a}]; // RULE3 RULE8
    if (is_common(a)) begin
      v = common_r[a[3:0]]; // RULE7
      if (a == rpl_pkg::ADDR_OPERATION_CONTROL) begin
        v = opc_value;
      end else if (a == rpl_pkg::ADDR_IND) begin
        v = ind_addr_r;
      end else if (a == rpl_pkg::ADDR_REGCTL) begin
        v = '0;
        v[rpl_pkg::RC_PAGE] = page_r;
        v[rpl_pkg::RC_BROADCAST_READ_ENABLE] = broadcast_read_enable_r;
        v[rpl_pkg::RC_MLK_LO +: 2] = mlk_r;
        v[rpl_pkg::RC_CONF] = conf_r;
      end
    end
    return v;
  endfunction

  always_comb begin
    host_ok = host_req && !blocked(host_addr);
    host_wr = host_ok && host_we;
    host_main_wr = host_wr && !is_common(host_addr);
    regctl_wr = host_wr && (host_addr == rpl_pkg::ADDR_REGCTL);
    opc_we = host_wr && (host_addr == rpl_pkg::ADDR_OPERATION_CONTROL);
    core_wr = core_row_we && core_row_ready;
    unlock_ev = regctl_wr && (mlk_r == rpl_pkg::MLK_HELD) &&
                (host_wdata[rpl_pkg::RC_MLK_LO +: 2] == rpl_pkg::MLK_OPEN);
    read_conversion_command_addr = read_conversion_command_first ? ind_addr_r : ptr_r;
    read_conversion_command_idx = read_conversion_command_first ? 8'h00 : fast_idx_r;
  end

  // Host byte access, answered one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      host_ack <= 1'b0;
      host_refused <= 1'b0;
      host_rdata <= '0;
    end else begin
      host_ack <= host_ok;
      host_refused <= host_req && !host_ok; // RULE12
      if (host_ok && !host_we) begin
        host_rdata <= read_byte(host_addr); // RULE6
      end else if (host_req && !host_ok) begin
        host_rdata <= rpl_pkg::BLOCK_DATA;
      end
    end
  end

  // Internal copy always follows the core, lock or not
  always_ff @(posedge sys_clk) begin
    if (core_wr) begin
      for (int i = 0; i < RB; i++) begin
        mem_int[{core_page, core_row, 4'(i)}] <=
          core_row_data[8*(RB-1-i) +: 8]; // RULE5 RULE15
      end
    end
    if (host_main_wr) begin
      mem_int[{page_r, host_addr}] <= host_wdata;
    end
  end

  // Visible copy: core rows land whole, frozen to core updates while the lock is held; host bytes still land
  always_ff @(posedge sys_clk) begin
    if (resync_r) begin
      for (int i = 0; i < RB; i++) begin
        mem_vis[{resync_row_r, 4'(i)}] <=
          mem_int[{resync_row_r, 4'(i)}];
      end
    end
    if (core_wr && (mlk_r != rpl_pkg::MLK_HELD)) begin
      for (int i = 0; i < RB; i++) begin
        mem_vis[{core_page, core_row, 4'(i)}] <=
          core_row_data[8*(RB-1-i) +: 8]; // RULE14 RULE16
      end
    end
    if (host_main_wr) begin
      mem_vis[{page_r, host_addr}] <= host_wdata;
    end
  end

  // Catch-up after unlock; host main-page access waits it out
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      resync_r <= 1'b0;
      resync_row_r <= '0;
    end else if (unlock_ev) begin
      resync_r <= 1'b1;
      resync_row_r <= '0;
    end else if (resync_r) begin
      resync_row_r <= resync_row_r + 1'b1;
      if (resync_row_r == rpl_pkg::RESYNC_LAST) begin
        resync_r <= 1'b0;
      end
    end
  end

  // Core rows wait while a host burst is open, so a burst sees one row
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      core_row_ready <= 1'b1;
    end else begin
      core_row_ready <= !host_burst; // RULE16
    end
  end

  // Register control; the grant wins over a host lock-field write in that cycle, other fields still take the write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      page_r <= 1'b0;
      broadcast_read_enable_r <= 1'b0;
      conf_r <= rpl_pkg::RC_CONF_RST;
      mlk_r <= rpl_pkg::MLK_OPEN;
    end else begin
      if (regctl_wr) begin
        page_r <= host_wdata[rpl_pkg::RC_PAGE]; // RULE8
        broadcast_read_enable_r <= host_wdata[rpl_pkg::RC_BROADCAST_READ_ENABLE]; // RULE9
        conf_r <= host_wdata[rpl_pkg::RC_CONF]; // RULE10
      end
      if ((mlk_r == rpl_pkg::MLK_REQ) && !core_busy && !resync_r) begin
        mlk_r <= rpl_pkg::MLK_HELD; // RULE13
      end else if (regctl_wr) begin
        if (host_wdata[rpl_pkg::RC_MLK_LO +: 2] == rpl_pkg::MLK_OPEN) begin
          mlk_r <= rpl_pkg::MLK_OPEN; // RULE14
        end else if ((host_wdata[rpl_pkg::RC_MLK_LO +: 2] ==
                      rpl_pkg::MLK_REQ) &&
                     (mlk_r == rpl_pkg::MLK_OPEN)) begin
          mlk_r <= rpl_pkg::MLK_REQ; // RULE11
        end
      end
    end
  end

  // Indirect address and spare common bytes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ind_addr_r <= '0;
      for (int i = 0; i < RB; i++) begin
        common_r[i] <= '0;
      end
    end else if (host_wr && is_common(host_addr)) begin
      common_r[host_addr[3:0]] <= host_wdata;
      if (host_addr == rpl_pkg::ADDR_IND) begin
        ind_addr_r <= host_wdata;
      end
    end
  end

  // Read-conversion stream; fast results ignore the lock
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      read_conversion_command_ack <= 1'b0;
      read_conversion_command_rdata <= '0;
      ptr_r <= '0;
      fast_idx_r <= '0;
    end else begin
      read_conversion_command_ack <= 1'b0;
      if (read_conversion_command_req && (!read_conversion_command_bcast || broadcast_read_enable_r)) begin // RULE9
        read_conversion_command_ack <= 1'b1;
        if (conf_r) begin
          read_conversion_command_rdata <= fast_result[8*read_conversion_command_idx +: 8]; // RULE6 RULE10
          if (read_conversion_command_idx == 8'(FAST_BYTES - 1)) begin
            fast_idx_r <= '0;
          end else begin
            fast_idx_r <= read_conversion_command_idx + 1'b1;
          end
        end else begin
          read_conversion_command_rdata <= blocked(read_conversion_command_addr) ? rpl_pkg::BLOCK_DATA :
                        read_byte(read_conversion_command_addr); // RULE6 RULE10
          ptr_r <= read_conversion_command_addr + 1'b1;
        end
      end
    end
  end

  rpl_operation_control #(
    .UPD_CYCLES(UPD_CYCLES)
  ) u_operation_control (
    .sys_clk(sys_clk),
    .srst(srst),
    .wr_en(opc_we),
    .wr_data(host_wdata),
    .opc_value(opc_value),
    .wake(!chip_select_n || iso_wake),
    .reset_unlock(reset_unlock),
    .meas_done(meas_done),
    .clear_done(clear_done),
    .meas_start_r(meas_start),
    .accum_enable_r(accum_enable),
    .clear_accum_r(clear_accum),
    .cfg_apply_r(cfg_apply),
    .soft_reset_r(soft_reset),
    .state_r(core_state)
  );
endmodule
`default_nettype wire

// ==== tb/rpl_regbank_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module rpl_regbank_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Host side
  input wire logic host_req,
  input wire logic host_burst,
  input wire logic host_ack,
  input wire logic host_refused,
  input wire logic [7:0] host_rdata,
  // Conversion read
  input wire logic read_conversion_command_req,
  input wire logic read_conversion_command_bcast,
  input wire logic read_conversion_command_ack,
  // Core control
  input wire logic reset_unlock,
  input wire logic core_row_ready,
  input wire logic meas_start,
  input wire logic accum_enable,
  input wire logic soft_reset,
  input wire rpl_pkg::rpl_core_t core_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  chk_host_answer:
    assert property (host_req |=> host_ack ^ host_refused)
    else $error("host access not answered exactly once");
  chk_host_stray:
    assert property (!host_req |=> !host_ack && !host_refused)
    else $error("host answer without request");
  chk_refuse_data:
    assert property (host_refused |-> host_rdata == 8'hFF)
    else $error("refused access without blank data");
  chk_read_conversion_command_answer:
    assert property (read_conversion_command_req && !read_conversion_command_bcast |=> read_conversion_command_ack)
    else $error("conversion read not answered");
  chk_read_conversion_command_stray:
    assert property (!read_conversion_command_req |=> !read_conversion_command_ack)
    else $error("conversion answer without request");
  chk_burst_hold:
    assert property (host_burst |=> !core_row_ready)
    else $error("row update open during burst");
  chk_reset_locked:
    assert property (soft_reset |-> $past(reset_unlock))
    else $error("device reset while locked");
  chk_start_measure:
    assert property (meas_start |->
      core_state == rpl_pkg::CS_MEASURE ##1 !meas_start)
    else $error("measure start outside measure state");
  chk_accum_measure:
    assert property (accum_enable |->
      $past(core_state) == rpl_pkg::CS_MEASURE)
    else $error("accumulation outside measure state");
endmodule
bind rpl_regbank rpl_regbank_asserts chk (.*);
`default_nettype wire

// ==== tb/rpl_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module rpl_host_model (
  // Clock
  input wire logic sys_clk,
  // Requests
  output logic host_req,
  output logic host_we,
  output logic [7:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_burst,
  // Answers
  input wire logic host_ack,
  input wire logic host_refused,
  input wire logic [7:0] host_rdata
);
  logic ack_q, ref_q, spin_q;
  logic [7:0] rd_q;
  initial begin
    host_req = 1'b0;
    host_we = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
    host_burst = 1'b0;
  end
  task xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    host_req = 1'b1;
    host_we = we;
    host_addr = a;
    host_wdata = d;
    @(posedge sys_clk);
    #1;
    // The answer stands only in the cycle after the taking edge
    ack_q = host_ack;
    ref_q = host_refused;
    rd_q = host_rdata;
    host_req = 1'b0;
    // Released lines must not keep a value the device could reuse
    host_addr = ~a;
    host_wdata = ~d;
  endtask
  task acc(input logic we, input logic [7:0] a, input logic [7:0] d);
    spin_q = 1'b0;
    if (we && a == rpl_pkg::ADDR_OPERATION_CONTROL) begin
      xfer(1'b0, a, 8'h00);
      for (int i = 0; i < 60 && (rd_q & 8'hA6) !== 8'h00; i++) begin
        xfer(1'b0, a, 8'h00);
      end
      // A poll that runs out is reported, not hidden behind the write
      spin_q = (rd_q & 8'hA6) !== 8'h00;
      d = d & 8'hAF;
    end
    xfer(we, a, d);
  endtask
  task burst(input logic b);
    @(posedge sys_clk);
    #1;
    host_burst = b;
  endtask
endmodule
`default_nettype wire

// ==== tb/rpl_regbank_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module rpl_regbank_test;
  logic sys_clk, srst, host_req, host_we, host_burst, host_ack;
  logic host_refused, read_conversion_command_req, read_conversion_command_first, read_conversion_command_bcast, read_conversion_command_ack;
  logic [7:0] host_addr, host_wdata, host_rdata, read_conversion_command_rdata;
  logic [23:0] fast_result;
  logic core_row_we, core_page, core_busy, core_row_ready;
  logic [3:0] core_row;
  logic [127:0] core_row_data;
  logic chip_select_n, iso_wake, reset_unlock, meas_done, clear_done;
  logic meas_start, accum_enable, clear_accum, cfg_apply, soft_reset;
  rpl_pkg::rpl_core_t core_state;
  int errors, checked, cycles;
  logic [24:0] tbl [14];
  rpl_regbank #(.FAST_BYTES(3), .UPD_CYCLES(8)) dut (.*);
  rpl_host_model host (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Ceiling is well above the few hundred cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      final_report;
    end
  end
  task final_report;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t byte %h want %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t bit %b want %b", $time, g, e);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task st(input rpl_pkg::rpl_core_t e);
    chk1(core_state == e, 1'b1);
  endtask
  task hc(input logic w, input logic [7:0] a, input logic [7:0] d,
          input logic r, input logic [7:0] e);
    host.acc(w, a, d);
    chk1(host.spin_q, 1'b0);
    chk1(host.ack_q, !r);
    chk1(host.ref_q, r);
    if (!w) chk8(host.rd_q, e);
  endtask
  task rc(input logic f, input logic b, input logic a, input logic [7:0] e);
    tk(1);
    read_conversion_command_req = 1'b1;
    read_conversion_command_first = f;
    read_conversion_command_bcast = b;
    tk(1);
    read_conversion_command_req = 1'b0;
    chk1(read_conversion_command_ack, a);
    if (a) chk8(read_conversion_command_rdata, e);
  endtask
  task pulse_done;
    meas_done = 1'b1;
    tk(1);
    meas_done = 1'b0;
    tk(1);
  endtask
  initial begin
    errors = 0;
    checked = 0;
    cycles = 0;
    srst = 1'b1;
    {read_conversion_command_req, read_conversion_command_first, read_conversion_command_bcast, core_row_we, core_busy} = 5'h00;
    {iso_wake, reset_unlock, meas_done, clear_done} = 4'h0;
    chip_select_n = 1'b1;
    core_page = 1'b0;
    core_row = 4'h1;
    fast_result = 24'hCCBBAA;
    core_row_data = {8'h33, 8'h44, 112'h0};
    tbl = '{25'h0FF0080, 25'h0F00000, 25'h1F15A00, 25'h0F1005A,
            25'h1FF8100, 25'h1102200, 25'h0FF0081, 25'h1FF8000,
            25'h1101100, 25'h0100011, 25'h1FF8100, 25'h0100022,
            25'h0F1005A, 25'h1FF8000};
    tk(10);
    srst = 1'b0;
    foreach (tbl[i]) begin
      hc(tbl[i][24], tbl[i][23:16], tbl[i][15:8], 1'b0, tbl[i][7:0]);
    end
    core_busy = 1'b1;
    hc(1'b1, 8'hFF, 8'h10, 1'b0, 8'h00);
    hc(1'b0, 8'h10, 8'h00, 1'b1, 8'hFF);
    hc(1'b0, 8'hFC, 8'h00, 1'b0, 8'h00);
    hc(1'b0, 8'hFF, 8'h00, 1'b0, 8'h10);
    core_busy = 1'b0;
    hc(1'b0, 8'hFF, 8'h00, 1'b0, 8'h20);
    core_row_we = 1'b1;
    tk(1);
    core_row_we = 1'b0;
    hc(1'b0, 8'h10, 8'h00, 1'b0, 8'h11);
    hc(1'b1, 8'hFF, 8'h00, 1'b0, 8'h00);
    tk(40);
    hc(1'b0, 8'h10, 8'h00, 1'b0, 8'h33);
    hc(1'b0, 8'h11, 8'h00, 1'b0, 8'h44);
    hc(1'b1, 8'hFC, 8'h10, 1'b0, 8'h00);
    rc(1'b1, 1'b0, 1'b1, 8'h33);
    rc(1'b0, 1'b0, 1'b1, 8'h44);
    rc(1'b1, 1'b1, 1'b0, 8'h00);
    hc(1'b1, 8'hFF, 8'h84, 1'b0, 8'h00);
    rc(1'b1, 1'b1, 1'b1, 8'hAA);
    rc(1'b0, 1'b0, 1'b1, 8'hBB);
    host.burst(1'b1);
    tk(2);
    chk1(core_row_ready, 1'b0);
    host.burst(1'b0);
    tk(2);
    chk1(core_row_ready, 1'b1);
    hc(1'b1, 8'hF0, 8'h04, 1'b0, 8'h00);
    tk(1);
    st(rpl_pkg::CS_MEASURE);
    chk1(meas_start, 1'b1);
    pulse_done;
    st(rpl_pkg::CS_STANDBY);
    hc(1'b0, 8'hF0, 8'h00, 1'b0, 8'h00);
    hc(1'b1, 8'hF0, 8'h02, 1'b0, 8'h00);
    chk1(clear_accum, 1'b1);
    hc(1'b0, 8'hF0, 8'h00, 1'b0, 8'h02);
    clear_done = 1'b1;
    tk(1);
    clear_done = 1'b0;
    tk(1);
    hc(1'b0, 8'hF0, 8'h00, 1'b0, 8'h00);
    hc(1'b1, 8'hF0, 8'h20, 1'b0, 8'h00);
    for (int i = 0; i < 20 && cfg_apply !== 1'b1; i++) tk(1);
    chk1(cfg_apply, 1'b1);
    hc(1'b0, 8'hF0, 8'h00, 1'b0, 8'h00);
    hc(1'b1, 8'hF0, 8'h80, 1'b0, 8'h00);
    chk1(soft_reset, 1'b0);
    hc(1'b0, 8'hF0, 8'h00, 1'b0, 8'h00);
    hc(1'b1, 8'hF0, 8'h08, 1'b0, 8'h00);
    tk(3);
    chk1(accum_enable, 1'b1);
    hc(1'b1, 8'hF0, 8'h0C, 1'b0, 8'h00);
    pulse_done;
    chk1(accum_enable, 1'b0);
    hc(1'b0, 8'hF0, 8'h00, 1'b0, 8'h04);
    pulse_done;
    st(rpl_pkg::CS_STANDBY);
    for (int w = 0; w < 2; w++) begin
      hc(1'b1, 8'hF0, 8'h01, 1'b0, 8'h00);
      tk(2);
      st(rpl_pkg::CS_SLEEP);
      if (w == 0) chip_select_n = 1'b0;
      else iso_wake = 1'b1;
      tk(1);
      iso_wake = 1'b0;
      tk(3);
      chip_select_n = 1'b1;
      st(rpl_pkg::CS_STANDBY);
    end
    srst = 1'b1;
    tk(2);
    srst = 1'b0;
    hc(1'b0, 8'hFF, 8'h00, 1'b0, 8'h80);
    reset_unlock = 1'b1;
    hc(1'b1, 8'hF0, 8'h80, 1'b0, 8'h00);
    chk1(soft_reset, 1'b1);
    final_report;
  end
endmodule
`default_nettype wire
